// ### pkg/dtm_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef DTM_CONSTS_SVH
`define DTM_CONSTS_SVH
// ======================================================
// register offsets
`define DTM_A_LOCAL    8'h00
`define DTM_A_REM_INT  8'h01
`define DTM_A_STATUS   8'h02
`define DTM_A_CFG_RD   8'h03
`define DTM_A_RATE_RD  8'h04
`define DTM_A_LHI      8'h05
`define DTM_A_LLO      8'h06
`define DTM_A_RHI      8'h07
`define DTM_A_RLO      8'h08
`define DTM_A_CFG_WR   8'h09
`define DTM_A_RATE_WR  8'h0a
`define DTM_A_REM_FRAC 8'h10
`define DTM_A_RTHERM   8'h19
`define DTM_A_LTHERM   8'h20
// ======================================================
// config and status fields
`define DTM_CFG_MASK   7
`define DTM_CFG_STBY   6
`define DTM_CFG_PIN2   5
`define DTM_CFG_EXT    2
`define DTM_CFG_WMASK  8'he4
`define DTM_ST_BUSY    7
`define DTM_ST_LHI     6
`define DTM_ST_LLO     5
`define DTM_ST_RHI     4
`define DTM_ST_RLO     3
`define DTM_ST_FAULT   2
`define DTM_ST_RTH     1
`define DTM_ST_LTH     0
// ======================================================
// reset values and limit slots
`define DTM_RST_CFG    8'h00
`define DTM_RST_RATE   4'h8
`define DTM_RST_HI     8'h55
`define DTM_RST_LO     8'h00
`define DTM_RST_OVERTEMP_COMPARATOR_N  8'h55
`define DTM_LIM_N      6
`define DTM_LIM_NONE   3'd7
// ======================================================
// conversion timing and format
`define DTM_RATE_MAX   4'ha
`define DTM_RATE_NOAVG 4'h8
`define DTM_AVG_N      16
`define DTM_AVG_SH     4
`define DTM_EXT_OFS    12'sd64
`define DTM_BIN_TOP    12'sd127
`define DTM_EXT_TOP    12'sd255
`define DTM_CLK_KHZ    10000
`define DTM_SLOW_MS    16000
`define DTM_SLOW_CYC   (`DTM_SLOW_MS * `DTM_CLK_KHZ)
`endif

// ### pkg/dtm_pkg.sv
// shared types of the temperature monitor core
package dtm_pkg;
  // conversion sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_START, SQ_WAIT, SQ_STORE} dtm_seq_t;
  // serial slave states
  typedef enum logic [3:0] {
    SM_IDLE, SM_ADDR, SM_AACK, SM_PTR, SM_PACK, SM_WDAT, SM_WACK, SM_RDAT, SM_RACK
  } dtm_smb_t;
endpackage

// ### pkg/dtm_link_if.sv
// register access handshake between the serial slave and the core
interface dtm_link_if;
  logic       req_tgl;  // toggles once per access
  logic       req_wr;   // 1 write, 0 read
  logic [7:0] ptr;      // register pointer
  logic [7:0] wdata;    // write byte
  logic       ack_tgl;  // follows req_tgl when done
  logic [7:0] rdata;    // read byte, stable after ack
  modport link (output req_tgl, req_wr, ptr, wdata, input ack_tgl, rdata);
  modport core (input req_tgl, req_wr, ptr, wdata, output ack_tgl, rdata);
endinterface

// ### hw/dtm_smb_slave.sv
// serial bus slave on the link clock, hands register accesses to the core
module dtm_smb_slave
  import dtm_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h2a  // bus address, arbitrary value
)(
  input  logic       clk_link,
  input  logic       ce,
  input  logic       rst_n,
  input  logic       scl_i,
  input  logic       sda_i,
  output logic       sda_oe,
  dtm_link_if.link   lk
);
  // ======================================================
  // synchronisers
  logic [1:0] scl_s, sda_s, ce_s, rst_s, ack_s;  // two-flop pairs
  logic       scl_d, sda_d;                      // previous settled level
  always_ff @(posedge clk_link)
  begin
    scl_s <= {scl_s[0], scl_i};
    sda_s <= {sda_s[0], sda_i};
    ce_s  <= {ce_s[0], ce};
    rst_s <= {rst_s[0], rst_n};
    ack_s <= {ack_s[0], lk.ack_tgl};
    scl_d <= scl_s[1];
    sda_d <= sda_s[1];
  end
  wire run      = rst_s[1];
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire bus_st   = scl_s[1] & scl_d & sda_d & ~sda_s[1];  // start or repeat
  wire bus_sp   = scl_s[1] & scl_d & ~sda_d & sda_s[1];  // stop
  wire pend     = lk.req_tgl ^ ack_s[1];                 // core still busy
  // ======================================================
  // byte engine
  dtm_smb_t   st_reg;
  logic [3:0] cnt_reg;  // bits seen in this byte
  logic [7:0] sh_reg;   // shift register
  logic [7:0] ptr_reg;  // pointer, zero after reset
  logic [7:0] wd_reg;
  logic       rw_reg, tgl_reg, wr_reg, oe_reg;
  // protocol walk; one request per data byte or read address
  always_ff @(posedge clk_link)
  begin
    if (!run)
    begin
      st_reg  <= SM_IDLE;
      cnt_reg <= 4'h0;
      sh_reg  <= 8'h00;
      ptr_reg <= 8'h00;
      wd_reg  <= 8'h00;
      rw_reg  <= 1'b0;
      tgl_reg <= 1'b0;
      wr_reg  <= 1'b0;
      oe_reg  <= 1'b0;
    end
    else if (ce_s[1])
    begin
      if (bus_st)
      begin
        st_reg  <= SM_ADDR;
        cnt_reg <= 4'h0;
        oe_reg  <= 1'b0;
      end
      else if (bus_sp)
      begin
        st_reg <= SM_IDLE;
        oe_reg <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (st_reg)
          SM_ADDR, SM_PTR, SM_WDAT:
          begin
            sh_reg  <= {sh_reg[6:0], sda_s[1]};
            cnt_reg <= cnt_reg + 4'h1;
          end
          SM_RACK: if (sda_s[1]) st_reg <= SM_IDLE;  // host nack ends read
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        case (st_reg)
          SM_ADDR:
            if (cnt_reg == 4'h8)
            begin
              st_reg  <= (sh_reg[7:1] == ADDR) ? SM_AACK : SM_IDLE;
              oe_reg  <= (sh_reg[7:1] == ADDR);
              rw_reg  <= sh_reg[0];
              wr_reg  <= 1'b0;
              tgl_reg <= tgl_reg ^ (sh_reg[7:1] == ADDR && sh_reg[0]);
            end
          SM_PTR:
            if (cnt_reg == 4'h8)
            begin
              ptr_reg <= sh_reg;
              oe_reg  <= 1'b1;
              st_reg  <= SM_PACK;
            end
          SM_WDAT:
            if (cnt_reg == 4'h8)
            begin
              wd_reg  <= sh_reg;
              wr_reg  <= 1'b1;
              tgl_reg <= ~tgl_reg;
              oe_reg  <= 1'b1;
              st_reg  <= SM_WACK;
            end
          SM_AACK, SM_RACK:
          begin
            cnt_reg <= 4'h0;
            sh_reg  <= lk.rdata;
            oe_reg  <= rw_reg & ~lk.rdata[7];
            st_reg  <= rw_reg ? SM_RDAT : SM_PTR;
          end
          SM_PACK, SM_WACK:
          begin
            oe_reg  <= 1'b0;
            cnt_reg <= 4'h0;
            st_reg  <= SM_WDAT;
          end
          SM_RDAT:
            if (cnt_reg == 4'h7)
            begin
              oe_reg <= 1'b0;
              st_reg <= SM_RACK;
            end
            else
            begin
              cnt_reg <= cnt_reg + 4'h1;
              sh_reg  <= {sh_reg[6:0], 1'b0};
              oe_reg  <= ~sh_reg[6];
            end
          default: ;
        endcase
      end
    end
  end
  assign lk.req_tgl = tgl_reg;
  assign lk.req_wr  = wr_reg;
  assign lk.ptr     = ptr_reg;
  assign lk.wdata   = wd_reg;
  assign sda_oe     = oe_reg;
  // ======================================================
  // checks
  chk_read_ready : assert property (@(posedge clk_link) disable iff (!run)
    (ce_s[1] && st_reg == SM_AACK && rw_reg && scl_fall && !bus_st && !bus_sp) |-> !pend)
    else $error("read byte not back from core before it is shifted out");
  chk_ack_release : assert property (@(posedge clk_link) disable iff (!run)
    (ce_s[1] && st_reg == SM_WACK && scl_fall && !bus_st && !bus_sp) |=> !oe_reg)
    else $error("data line still held after write acknowledge");
endmodule  // dtm_smb_slave

// ### hw/dtm_core.sv
// dual-channel temperature monitor core: sequencer, registers, limits, alarm pins
`include "dtm_consts.svh"

// What this block does
// - free-running conversions alternate local then remote
// - compare results to limits, flag in status
// - alarm pin low on limit or diode fault
// - comparator pin low above overtemperature limit
// - alarm pin can act as second comparator
// - host sets standby, scale, mask, pin, rate
// - config bits: 7 mask, 6 standby, 5 pin, 2 range
// - host writes limits, reads every register back
// - slow rates average sixteen measurement cycles
// - rates of 16, 32, 64 never average
// - bias steps I, N1*I, then I, N2*I
// - local whole degrees at offset 0x00
// - remote integer 0x01, fraction at 0x10
// - fraction uses top two bits only
// - reading one remote byte locks nothing
// - range bit 2 selects extended range
// - next measurement uses the new range
// - extended registers span -64 to +191
// - shorted diode keeps last good remote value
// - binary default, offset binary plus 64 extended
// - binary saturates at 0 and 127
module dtm_core
  import dtm_pkg::*;
#(
  parameter int          TEMP_W   = 12,                    // adc word, quarter degrees
  parameter logic [31:0] SLOW_CYC = 32'(`DTM_SLOW_CYC),    // pair period at code 0
  parameter logic [6:0]  SMB_ADDR = 7'h2a                  // bus address, arbitrary value
)(
  input  logic                     clk_sys,
  input  logic                     rst_n,
  input  logic                     ce,
  input  logic                     clk_link,
  input  logic                     smb_scl_i,
  input  logic                     smb_sda_i,
  output logic                     smb_sda_o,
  output logic                     smb_sda_oe,
  output logic                     alarm_n_o,
  output logic                     alarm_n_oe,
  output logic                     overtemp_comparator_n_o,
  output logic                     overtemp_comparator_n_oe,
  output logic                     adc_start,
  output logic                     adc_remote,
  output logic [1:0]               adc_bias,
  input  logic                     adc_done,
  input  logic signed [TEMP_W-1:0] adc_temp,
  input  logic                     adc_open,
  input  logic                     adc_short
);
  // ======================================================
  // serial link and request crossing
  dtm_link_if lk ();  // handshake between domains

  dtm_smb_slave #(.ADDR(SMB_ADDR)) u_smb (
    .clk_link (clk_link),
    .ce       (ce),
    .rst_n    (rst_n),
    .scl_i    (smb_scl_i),
    .sda_i    (smb_sda_i),
    .sda_oe   (smb_sda_oe),
    .lk       (lk.link)
  );

  logic [1:0] req_s;      // toggle synchroniser
  logic       req_d;      // last toggle served
  logic       ack_reg;    // answer toggle
  logic [7:0] rdata_reg;  // read byte held for the link
  logic [7:0] rd_val;     // read mux
  logic       zero_reg;   // open-drain data level
  wire        req_new = req_s[1] ^ req_d;
  wire        host_wr = ce & req_new & lk.req_wr;

  // ptr and wdata are stable while a request is in flight
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      req_s     <= 2'h0;
      req_d     <= 1'b0;
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
      zero_reg  <= 1'b0;
    end
    else if (ce)
    begin
      req_s <= {req_s[0], lk.req_tgl};
      if (req_new)
      begin
        req_d   <= req_s[1];
        ack_reg <= ~ack_reg;
        if (!lk.req_wr)
          rdata_reg <= rd_val;
      end
    end
  end
  assign lk.ack_tgl = ack_reg;
  assign lk.rdata   = rdata_reg;

  // ======================================================
  // host registers
  logic [7:0] cfg_reg;                  // mask, standby, pin, range
  logic [3:0] rate_reg;                 // conversion rate code
  logic [7:0] lim_reg [`DTM_LIM_N];     // lhi, llo, rhi, rlo, rtherm, ltherm
  logic [7:0] loc_reg;                  // local result
  logic [7:0] rint_reg;                 // remote integer byte
  logic [7:0] rfrac_reg;                // remote fraction byte
  logic [7:0] flags_reg;                // status byte
  localparam logic [7:0] LIM_RST [`DTM_LIM_N] = '{
    `DTM_RST_HI, `DTM_RST_LO, `DTM_RST_HI, `DTM_RST_LO, `DTM_RST_OVERTEMP_COMPARATOR_N, `DTM_RST_OVERTEMP_COMPARATOR_N};

  // limit slot of an address, none for other registers
  function automatic logic [2:0] lim_idx(input logic [7:0] a);
    case (a)
      `DTM_A_LHI:    lim_idx = 3'd0;
      `DTM_A_LLO:    lim_idx = 3'd1;
      `DTM_A_RHI:    lim_idx = 3'd2;
      `DTM_A_RLO:    lim_idx = 3'd3;
      `DTM_A_RTHERM: lim_idx = 3'd4;
      `DTM_A_LTHERM: lim_idx = 3'd5;
      default:       lim_idx = `DTM_LIM_NONE;
    endcase
  endfunction

  // writes from the host; reserved config bits are dropped
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cfg_reg  <= `DTM_RST_CFG;
      rate_reg <= `DTM_RST_RATE;
      for (int i = 0; i < `DTM_LIM_N; i++)
        lim_reg[i] <= LIM_RST[i];
    end
    else if (host_wr)
    begin
      if (lk.ptr == `DTM_A_CFG_WR)
        cfg_reg <= lk.wdata & `DTM_CFG_WMASK;
      if (lk.ptr == `DTM_A_RATE_WR)
        rate_reg <= lk.wdata[3:0];
      if (lim_idx(lk.ptr) != `DTM_LIM_NONE)
        lim_reg[lim_idx(lk.ptr)] <= lk.wdata;
    end
  end

  // read mux; remote bytes read live, nothing is frozen
  always_comb
  begin
    rd_val = 8'h00;
    case (lk.ptr)
      `DTM_A_LOCAL:    rd_val = loc_reg;
      `DTM_A_REM_INT:  rd_val = rint_reg;
      `DTM_A_REM_FRAC: rd_val = rfrac_reg;
      `DTM_A_STATUS:   rd_val = flags_reg;
      `DTM_A_CFG_RD:   rd_val = cfg_reg;
      `DTM_A_RATE_RD:  rd_val = {4'h0, rate_reg};
      default:
        if (lim_idx(lk.ptr) != `DTM_LIM_NONE)
          rd_val = lim_reg[lim_idx(lk.ptr)];
    endcase
  end

  // ======================================================
  // conversion sequencer
  dtm_seq_t                 seq_reg;
  logic                     rem_reg;    // 1 while converting the remote diode
  logic [1:0]               bias_reg;   // current step
  logic [4:0]               nmeas_reg;  // measurement cycles done
  logic                     avg_reg;    // averaging for this pair
  logic                     short_reg;  // short seen in this conversion
  logic                     fault_reg;  // last remote diode fault
  logic signed [TEMP_W+3:0] acc_reg;    // sum of measurements
  logic [31:0]              timer_reg;  // time to next pair
  logic                     start_reg;
  wire  [3:0]  rate_eff  = (rate_reg > `DTM_RATE_MAX) ? `DTM_RATE_MAX : rate_reg;
  wire  [31:0] period    = SLOW_CYC >> rate_eff;
  wire         last_meas = !avg_reg || (nmeas_reg == 5'(`DTM_AVG_N - 1));

  // pair timer runs on; a slow pair starts the next one at once
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      seq_reg   <= SQ_IDLE;
      rem_reg   <= 1'b0;
      bias_reg  <= 2'd0;
      nmeas_reg <= 5'd0;
      avg_reg   <= 1'b0;
      short_reg <= 1'b0;
      fault_reg <= 1'b0;
      acc_reg   <= '0;
      timer_reg <= 32'd0;
      start_reg <= 1'b0;
    end
    else if (ce)
    begin
      start_reg <= 1'b0;
      if (timer_reg != 32'd0)
        timer_reg <= timer_reg - 32'd1;
      case (seq_reg)
        SQ_IDLE:
          // standby holds here, a running pair always finishes
          if (timer_reg == 32'd0 && !cfg_reg[`DTM_CFG_STBY])
          begin
            timer_reg <= period - 32'd1;
            avg_reg   <= rate_reg < `DTM_RATE_NOAVG;
            rem_reg   <= 1'b0;
            seq_reg   <= SQ_START;
          end
        SQ_START:
        begin
          start_reg <= 1'b1;
          seq_reg   <= SQ_WAIT;
        end
        SQ_WAIT:
          if (adc_done)
          begin
            short_reg <= short_reg | (rem_reg & adc_short);
            seq_reg   <= SQ_START;
            bias_reg  <= bias_reg + 2'd1;
            if (bias_reg == 2'd3)
            begin
              acc_reg   <= acc_reg + (TEMP_W+4)'(adc_temp);
              nmeas_reg <= nmeas_reg + 5'd1;
              if (last_meas)
                seq_reg <= SQ_STORE;
            end
          end
        SQ_STORE:
        begin
          acc_reg   <= '0;
          nmeas_reg <= 5'd0;
          short_reg <= 1'b0;
          rem_reg   <= ~rem_reg;
          seq_reg   <= rem_reg ? SQ_IDLE : SQ_START;
          if (rem_reg)
            fault_reg <= adc_open | short_reg;
        end
        default: seq_reg <= SQ_IDLE;
      endcase
    end
  end
  assign adc_start  = start_reg;
  assign adc_remote = rem_reg;
  assign adc_bias   = bias_reg;

  // ======================================================
  // result encoding and storage
  // {saturated, byte} of a quarter-degree value in the chosen format
  function automatic logic [8:0] dtm_enc(input logic signed [TEMP_W-1:0] q,
                                         input logic ext);
    logic signed [11:0] d;
    logic signed [11:0] top;
    d   = 12'(q >>> 2) + (ext ? `DTM_EXT_OFS : 12'sd0);
    top = ext ? `DTM_EXT_TOP : `DTM_BIN_TOP;
    if (d < 12'sd0)
      dtm_enc = 9'h100;
    else if (d > top)
      dtm_enc = {1'b1, top[7:0]};
    else
      dtm_enc = {1'b0, d[7:0]};
  endfunction

  wire signed [TEMP_W-1:0] result =
    avg_reg ? TEMP_W'(acc_reg >>> `DTM_AVG_SH) : acc_reg[TEMP_W-1:0];
  // format follows the range bit at store time
  wire [8:0] enc = dtm_enc(result, cfg_reg[`DTM_CFG_EXT]);
  wire       rstore = ce && seq_reg == SQ_STORE && rem_reg && !short_reg;

  // both remote bytes land in one cycle, so they always match
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      loc_reg   <= 8'h00;
      rint_reg  <= 8'h00;
      rfrac_reg <= 8'h00;
    end
    else if (ce && seq_reg == SQ_STORE && !rem_reg)
      loc_reg <= enc[7:0];
    else if (rstore)
    begin
      rint_reg  <= enc[7:0];
      rfrac_reg <= enc[8] ? 8'h00 : {result[1:0], 6'h00};
    end
  end

  // ======================================================
  // limit compare and alarm pins
  logic alarm_oe_reg;  // pin six pulled low
  logic over_oe_reg;   // comparator pin pulled low
  wire  overtemp_comparator_n_now = (loc_reg > lim_reg[5]) | (rint_reg > lim_reg[4]);
  wire  alarm_now = |flags_reg[`DTM_ST_LHI:`DTM_ST_FAULT];

  // flags follow the stored results and limits, also in standby
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flags_reg <= 8'h00;
    else if (ce)
    begin
      flags_reg[`DTM_ST_BUSY]  <= seq_reg != SQ_IDLE;
      flags_reg[`DTM_ST_LHI]   <= loc_reg > lim_reg[0];
      flags_reg[`DTM_ST_LLO]   <= loc_reg < lim_reg[1];
      flags_reg[`DTM_ST_RHI]   <= rint_reg > lim_reg[2];
      flags_reg[`DTM_ST_RLO]   <= rint_reg < lim_reg[3];
      flags_reg[`DTM_ST_FAULT] <= fault_reg;
      flags_reg[`DTM_ST_RTH]   <= rint_reg > lim_reg[4];
      flags_reg[`DTM_ST_LTH]   <= loc_reg > lim_reg[5];
    end
  end

  // mask only applies while pin six is the alarm
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      alarm_oe_reg <= 1'b0;
      over_oe_reg  <= 1'b0;
    end
    else if (ce)
    begin
      over_oe_reg <= overtemp_comparator_n_now;
      if (cfg_reg[`DTM_CFG_PIN2])
        alarm_oe_reg <= overtemp_comparator_n_now;
      else
        alarm_oe_reg <= alarm_now & ~cfg_reg[`DTM_CFG_MASK];
    end
  end
  assign alarm_n_o                = zero_reg;
  assign alarm_n_oe               = alarm_oe_reg;
  assign overtemp_comparator_n_o  = zero_reg;
  assign overtemp_comparator_n_oe = over_oe_reg;
  assign smb_sda_o                = zero_reg;

  // ======================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_local_then_remote : assert property (
    (ce && seq_reg == SQ_STORE && !rem_reg) |=> (rem_reg && seq_reg == SQ_START))
    else $error("remote conversion did not follow local");
  chk_flag_high : assert property (ce && rint_reg > lim_reg[2] |=> flags_reg[4])
    else $error("remote high flag missing");
  chk_alarm_low : assert property (
    (ce && !cfg_reg[5] && !cfg_reg[7] && flags_reg[2]) |=> alarm_n_oe)
    else $error("alarm not driven on diode fault");
  chk_comparator_low : assert property (ce && overtemp_comparator_n_now |=> ##0 overtemp_comparator_n_oe)
    else $error("comparator pin not driven over limit");
  chk_pin_two : assert property (ce && cfg_reg[5] |=> alarm_n_oe == $past(overtemp_comparator_n_now))
    else $error("pin six not following comparator");
  chk_standby_hold : assert property (
    (ce && seq_reg == SQ_IDLE && cfg_reg[6]) |=> seq_reg == SQ_IDLE)
    else $error("conversion started in standby");
  chk_average_count : assert property (
    (seq_reg == SQ_STORE && avg_reg) |-> nmeas_reg == 5'd16)
    else $error("averaged result not made of sixteen cycles");
  chk_single_count : assert property (
    (seq_reg == SQ_STORE && !avg_reg) |-> nmeas_reg == 5'd1)
    else $error("fast rate result averaged");
  chk_bias_step : assert property (
    (ce && seq_reg == SQ_WAIT && adc_done) |=> bias_reg == $past(bias_reg) + 2'd1)
    else $error("bias step out of order");
  chk_fraction_low : assert property (rfrac_reg[5:0] == 6'h00)
    else $error("fraction low bits not zero");
  chk_remote_pair : assert property (
    (rint_reg != $past(rint_reg) || rfrac_reg != $past(rfrac_reg)) |-> $past(rstore))
    else $error("remote bytes changed outside a store");
  chk_binary_sat : assert property (
    (ce && seq_reg == SQ_STORE && !rem_reg && !cfg_reg[2]) |=> loc_reg <= 8'h7f)
    else $error("binary local result above 127");

  cov_remote_store : cover property (rstore);
  cov_avg_store    : cover property (ce && seq_reg == SQ_STORE && avg_reg);
  cov_alarm_rise   : cover property ($rose(alarm_n_oe));
  cov_host_write   : cover property (host_wr);
endmodule  // dtm_core

// ### testbench/dtm_smb_host.sv
// two-wire bus host model that reads and writes the monitor's registers
module dtm_smb_host (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_oe,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       r;  // last bit seen on the wire
  logic [7:0] x;  // scratch byte
  initial scl = 1'b1;
  initial sda_oe = 1'b0;
  // ==========================================
  // bus phases
  // one third of a bit: slow, so the device's pin sync never sees scl and sda move together
  task automatic ph(input logic c, input logic d);
    scl <= c;
    sda_oe <= d;
    repeat (4) @(posedge clk);
  endtask
  // one bit: scl falls first, then data moves, then scl rises and the wire is sampled
  task automatic bt(input logic b);
    ph(1'b0, sda_oe);
    ph(1'b0, !b);
    ph(1'b1, !b);
    r = sda;
  endtask
  // start or repeated start
  task automatic st();
    ph(1'b0, sda_oe);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // stop
  task automatic sp();
    ph(1'b0, sda_oe);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  // ==========================================
  // transfers
  // eight bits, then the ninth bit driven as a (1 releases)
  task automatic by(input logic [7:0] d, input logic a, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      bt(d[i]);
      q[i] = r;
    end
    bt(a);
  endtask
  // write one byte at a pointer; 8'h54 is the default address with write direction
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    st();
    by(8'h54, 1'b1, x);
    by(p, 1'b1, x);
    by(d, 1'b1, x);
    sp();
  endtask
  // pointer write, repeated start, one byte read and refused; kept short so pairs stay coherent
  task automatic rd(input logic [7:0] p, output logic [7:0] q);
    st();
    by(8'h54, 1'b1, x);
    by(p, 1'b1, x);
    st();
    by(8'h55, 1'b1, x);
    by(8'hff, 1'b1, q);
    sp();
  endtask
endmodule // dtm_smb_host

// ### testbench/tb_dual_channel_temp_monitor_core.sv
// self-checking bench of the temperature monitor core
module tb_dual_channel_temp_monitor_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, clk_link = 0, rst_n = 0, d1 = 0, adc_done = 0, adc_short = 0, ot;
  logic smb_scl_i, hoe, smb_sda_oe, adc_start, adc_remote, alarm_n_oe, overtemp_comparator_n_oe;
  logic [1:0]         adc_bias;
  logic signed [11:0] adc_temp = 0;
  logic [7:0]         q, c, el, ei, ef;
  logic [7:0]         cfgs [4] = '{8'h00, 8'h80, 8'hbf, 8'h04};
  int                 lt = 0, rt = 0, n_errors = 0, total_checks = 0, cyc = 0;
  wire                smb_sda_i = !(hoe | smb_sda_oe);  // pulled-up data wire
  `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h, expected %h", $time, a, e); end end
  initial forever #50 clk_sys = !clk_sys;
  initial forever #40 clk_link = !clk_link;
  dtm_core #(.SLOW_CYC(32'd4096)) u_dut (.clk_sys, .rst_n, .ce(1'b1), .clk_link, .smb_scl_i,
    .smb_sda_i, .smb_sda_o(), .smb_sda_oe, .alarm_n_o(), .alarm_n_oe,
    .overtemp_comparator_n_o(), .overtemp_comparator_n_oe, .adc_start, .adc_remote,
    .adc_bias, .adc_done, .adc_temp, .adc_open(1'b0), .adc_short);
  dtm_smb_host u_host (.clk(clk_link), .scl(smb_scl_i), .sda_oe(hoe), .sda(smb_sda_i));
  // front end: step done two cycles after start, result of the selected channel
  always @(posedge clk_sys)
  begin
    d1 <= adc_start;
    adc_done <= d1;
    adc_temp <= 12'(adc_remote ? rt : lt);
    cyc <= cyc + 1;
  end
  // hang guard, well above the expected run
  always @(posedge clk_sys)
    if (cyc > 30000)
    begin
      n_errors++;
      test_done();
    end
  // expected register byte from quarter degrees and the range bit
  function automatic logic [7:0] enc(int t);
    int d = (t >>> 2) + (c[2] ? 64 : 0);
    return (d < 0) ? 8'h00 : (d > (c[2] ? 255 : 127)) ? (c[2] ? 8'hff : 8'h7f) : 8'(d);
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // main sequence: one pass per configuration
  initial
  begin
    void'($urandom(32'h6a10));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    for (int k = 0; k < 4; k++)
    begin
      c = cfgs[k];
      @(posedge clk_sys);
      lt <= (k == 1) ? -160 : $urandom_range(508, 0);
      rt <= (k == 1) ? 600 : $urandom_range(k > 1 ? 760 : 508, 0);
      // from the third pass on a slow rate averages sixteen measurements
      if (k == 2)
        u_host.wr(8'h0a, 8'h07);
      u_host.wr(8'h09, c);
      // long enough for two averaged pairs after the change
      repeat (1200) @(posedge clk_sys);
      u_host.rd(8'h03, q);
      `CHK(q, c & 8'he4)
      el = enc(lt);
      ei = enc(rt);
      ef = (c[2] || rt < 512) ? {rt[1:0], 6'h00} : 8'h00;
      ot = (el > 8'h55) || (ei > 8'h55);
      u_host.rd(8'h00, q);
      `CHK(q, el)
      u_host.rd(8'h01, q);
      `CHK(q, ei)
      u_host.rd(8'h10, q);
      `CHK(q, ef)
      `CHK(overtemp_comparator_n_oe, ot)
      `CHK(alarm_n_oe, c[5] ? ot : ot & !c[7])
    end
    // shorted diode with a new remote value: old byte stays, fault raises the alarm
    @(posedge clk_sys);
    adc_short <= 1'b1;
    rt <= rt + 40;
    repeat (1200) @(posedge clk_sys);
    u_host.rd(8'h01, q);
    `CHK(q, ei)
    `CHK(alarm_n_oe, 1'b1)
    // standby: the pair in flight ends under the short, then nothing converts
    u_host.wr(8'h09, 8'h44);
    repeat (1200) @(posedge clk_sys);
    adc_short <= 1'b0;
    repeat (1200) @(posedge clk_sys);
    u_host.rd(8'h01, q);
    `CHK(q, ei)
    // a random limit reads back as written
    c = 8'($urandom);
    u_host.wr(8'h20, c);
    u_host.rd(8'h20, q);
    `CHK(q, c)
    test_done();
  end
endmodule // tb_dual_channel_temp_monitor_core
